// [include/adr_pkg.sv]
// Purpose: Shared constants and types for the amplifier control register bank
// Assumes: Byte-wide registers behind a two-wire serial control port
// Notes: Offsets are 7-bit register addresses within a page
package adr_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_PAGE_SEL = 7'h00;
  localparam logic [6:0] OFS_OUT_CFG = 7'h02;
  localparam logic [6:0] OFS_STATE_CTL = 7'h03;
  localparam logic [6:0] OFS_PAGE_INC = 7'h0F;
  localparam logic [6:0] OFS_FRAME_CFG = 7'h28;
  localparam logic [6:0] OFS_BOOK_SEL = 7'h7F;
  localparam logic [6:0] PAGE_END = 7'h7F;
  localparam logic [6:0] PAGE_WRAP_START = 7'h08;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OUT_CFG = 8'h00;
  localparam logic [7:0] RST_STATE_CTL = 8'h10;
  localparam logic [7:0] RST_PAGE_INC = 8'h00;
  localparam logic [7:0] RST_FRAME_CFG = 8'h00;
  localparam logic [7:0] GAIN_FULL = 8'hFF;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FSW_LSB = 4;
  localparam int BRIDGE_BIT = 2;
  localparam int MOD_LSB = 0;
  localparam int HOLD_BIT = 4;
  localparam int MUTE_BIT = 3;
  localparam int PSTATE_LSB = 0;
  localparam int WRAP_DIS_BIT = 3;
  localparam int BCLK_LSB = 4;
  localparam int FS_LSB = 0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_LAST = 8'(RAMP_STEP_CYC - 1);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_DEEP_SLEEP = 2'b00, PWR_SLEEP = 2'b01, PWR_HIZ = 2'b10, PWR_PLAY = 2'b11
  } adr_power_t;
  typedef enum logic [1:0] {
    MOD_BD = 2'b00, MOD_SINGLE_SIDE = 2'b01, MOD_HYBRID = 2'b10, MOD_RSVD = 2'b11
  } adr_mod_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001, ST_ADDR = 7'b000_0010, ST_AACK = 7'b000_0100,
    ST_RXD = 7'b000_1000, ST_DACK = 7'b001_0000, ST_TXD = 7'b010_0000,
    ST_TACK = 7'b100_0000
  } adr_state_t;
  typedef struct packed {
    logic [7:0] out_cfg;
    logic [7:0] state_ctl;
    logic [7:0] page_inc;
    logic [7:0] frame_cfg;
  } adr_regs_t;
  typedef struct packed {
    logic [7:0] book;
    logic [7:0] page;
    logic [6:0] ofs;
  } adr_ptr_t;
endpackage

// [hw/adr_ctrl_regs.sv]
// Purpose: Control port register bank of a stereo class-D amplifier
// Assumes: SCL and SDA inputs synchronous to CLK, CLK far faster than SCL
// Notes: Registers live in book 0 page 0; other pages read as zero except the page select at offset 0 and, on page 0 of any book, the book select at 0x7F
//
// Behaviour
// - Switching-frequency field selects 768, 384, 480 or 576 kHz; rest reserved.
// - Bridge bit: 0 bridge-tied load, 1 parallel bridge load.
// - Modulation field: 00 BD, 01 single-side pulse, 10 hybrid.
// - Processor hold resets to 1; clearing it starts processor power-up.
// - Power field: 00 deep sleep, 01 sleep, 10 high-Z, 11 play.
// - Non-zero book, wrap enabled: page end continues at next page address 8.
// - Non-zero book, wrap disabled: page end returns to address 0 same page.
// - Sample-rate code 0 selects auto, six codes fixed 8 to 96 kHz rates; rest reserved.
// - State control resets to 0x10, other three registers to 0x00.
`timescale 1ns/1ps
`default_nettype none
module adr_ctrl_regs
  import adr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [9:0] SW_FREQ_KHZ,
  output logic SW_FREQ_VALID,
  output logic BRIDGE_PARALLEL,
  output adr_mod_t MOD_SCHEME,
  output logic PROCESSOR_HOLD,
  output logic DSP_START,
  output logic MUTE_REQ,
  output logic [7:0] VOLUME_GAIN,
  output logic MUTE_DONE,
  output adr_power_t POWER_STATE,
  output logic [9:0] BITCLOCK_RATIO_FS,
  output logic BITCLOCK_VALID,
  output logic SAMPLE_RATE_AUTO,
  output logic [9:0] SAMPLE_RATE_KHZ10,
  output logic SAMPLE_RATE_VALID
);
  // ----------------------------------------------------------------
  // Line edge and frame condition detect
  // ----------------------------------------------------------------
  logic scl_ff, sda_ff;
  wire scl_rise = SCL & ~scl_ff;
  wire scl_fall = ~SCL & scl_ff;
  wire start_cond = SCL & scl_ff & sda_ff & ~SDA_IN;
  wire stop_cond = SCL & scl_ff & ~sda_ff & SDA_IN;

  adr_state_t state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic first_ff, nxt_first, rw_ff, nxt_rw, ack_ff, nxt_ack;
  logic wr_en, ptr_load, adv;
  adr_ptr_t ptr_ff, nxt_ptr;
  adr_regs_t regs_ff;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  wire in_base = (ptr_ff.book == 8'h00) && (ptr_ff.page == 8'h00);
  wire sel_page = ptr_ff.ofs == OFS_PAGE_SEL;
  wire sel_book = (ptr_ff.page == 8'h00) && (ptr_ff.ofs == OFS_BOOK_SEL);
  wire sel_out = in_base && (ptr_ff.ofs == OFS_OUT_CFG);
  wire sel_state = in_base && (ptr_ff.ofs == OFS_STATE_CTL);
  wire sel_inc = in_base && (ptr_ff.ofs == OFS_PAGE_INC);
  wire sel_frame = in_base && (ptr_ff.ofs == OFS_FRAME_CFG);
  wire wrap_dis = regs_ff.page_inc[WRAP_DIS_BIT];
  wire [7:0] rd_data = sel_page ? ptr_ff.page :
                       sel_book ? ptr_ff.book :
                       sel_out ? regs_ff.out_cfg :
                       sel_state ? regs_ff.state_ctl :
                       sel_inc ? regs_ff.page_inc :
                       sel_frame ? regs_ff.frame_cfg : 8'h00;

  // Open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = (state_ff == ST_AACK) || (state_ff == ST_DACK) ||
                  ((state_ff == ST_TXD) && ~shift_ff[7]);

  // ----------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_first = first_ff;
    nxt_rw = rw_ff;
    nxt_ack = ack_ff;
    wr_en = 1'b0;
    ptr_load = 1'b0;
    adv = 1'b0;
    if (start_cond) begin
      nxt_state = ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_first = 1'b1;
    end else if (stop_cond) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_ADDR, ST_RXD: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], SDA_IN};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == 4'h8) begin
            if (state_ff == ST_ADDR) begin
              nxt_rw = shift_ff[0];
              nxt_state = (shift_ff[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
            end else begin
              nxt_state = ST_DACK;
              ptr_load = first_ff;
              wr_en = ~first_ff;
              nxt_first = 1'b0;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            nxt_state = rw_ff ? ST_TXD : ST_RXD;
            nxt_shift = rw_ff ? rd_data : shift_ff;
            nxt_bitcnt = 4'h0;
          end
        end
        ST_DACK: begin
          if (scl_fall) begin
            nxt_state = ST_RXD;
            nxt_bitcnt = 4'h0;
          end
        end
        ST_TXD: begin
          if (scl_rise) begin
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_ff == 4'h8) begin
              nxt_state = ST_TACK;
              adv = 1'b1;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nxt_ack = ~SDA_IN;
          end else if (scl_fall) begin
            nxt_state = ack_ff ? ST_TXD : ST_IDLE;
            nxt_shift = rd_data;
            nxt_bitcnt = 4'h0;
          end
        end
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Book, page and address pointer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ptr = ptr_ff;
    if (ptr_load) begin
      nxt_ptr.ofs = shift_ff[6:0];
    end else begin
      if (wr_en && sel_page) begin
        nxt_ptr.page = shift_ff;
      end
      if (wr_en && sel_book) begin
        nxt_ptr.book = shift_ff;
      end
      if (wr_en || adv) begin
        if (nxt_ptr.ofs == PAGE_END) begin
          if (nxt_ptr.book != 8'h00 && !wrap_dis) begin
            nxt_ptr.page = nxt_ptr.page + 8'h01;
            nxt_ptr.ofs = PAGE_WRAP_START;
          end else begin
            nxt_ptr.ofs = 7'h00;
          end
        end else begin
          nxt_ptr.ofs = nxt_ptr.ofs + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      first_ff <= 1'b0;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      ptr_ff <= '0;
    end else begin
      scl_ff <= SCL;
      sda_ff <= SDA_IN;
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      first_ff <= nxt_first;
      rw_ff <= nxt_rw;
      ack_ff <= nxt_ack;
      ptr_ff <= nxt_ptr;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Reset values
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      regs_ff <= '{RST_OUT_CFG, RST_STATE_CTL, RST_PAGE_INC, RST_FRAME_CFG};
    end else if (wr_en) begin
      if (sel_out) regs_ff.out_cfg <= shift_ff;
      if (sel_state) regs_ff.state_ctl <= shift_ff;
      if (sel_inc) regs_ff.page_inc <= shift_ff;
      if (sel_frame) regs_ff.frame_cfg <= shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [2:0] fsw = regs_ff.out_cfg[FSW_LSB +: 3];
  wire [3:0] bclk = regs_ff.frame_cfg[BCLK_LSB +: 4];
  wire [3:0] fs = regs_ff.frame_cfg[FS_LSB +: 4];
  wire hold = regs_ff.state_ctl[HOLD_BIT];
  logic [9:0] nxt_sw_khz, nxt_bclk_fs, nxt_fs_khz10;
  logic hold_ff;

  always_comb begin
    case (fsw)
      3'b000: nxt_sw_khz = 10'd768;
      3'b001: nxt_sw_khz = 10'd384;
      3'b011: nxt_sw_khz = 10'd480;
      3'b100: nxt_sw_khz = 10'd576;
      default: nxt_sw_khz = 10'd0;
    endcase
    case (bclk)
      4'b0011: nxt_bclk_fs = 10'd32;
      4'b0101: nxt_bclk_fs = 10'd64;
      4'b0111: nxt_bclk_fs = 10'd128;
      4'b1001: nxt_bclk_fs = 10'd256;
      4'b1011: nxt_bclk_fs = 10'd512;
      default: nxt_bclk_fs = 10'd0;
    endcase
    // Fixed sample rate, tenths of kHz; shared code taken as 96k
    case (fs)
      4'b0010: nxt_fs_khz10 = 10'd80;
      4'b0100: nxt_fs_khz10 = 10'd160;
      4'b0110: nxt_fs_khz10 = 10'd320;
      4'b1000: nxt_fs_khz10 = 10'd441;
      4'b1001: nxt_fs_khz10 = 10'd480;
      4'b1011: nxt_fs_khz10 = 10'd960;
      default: nxt_fs_khz10 = 10'd0;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SW_FREQ_KHZ <= 10'd768;
      SW_FREQ_VALID <= 1'b1;
      BRIDGE_PARALLEL <= 1'b0;
      MOD_SCHEME <= MOD_BD;
      PROCESSOR_HOLD <= 1'b1;
      hold_ff <= 1'b1;
      DSP_START <= 1'b0;
      MUTE_REQ <= 1'b0;
      POWER_STATE <= PWR_DEEP_SLEEP;
      BITCLOCK_RATIO_FS <= 10'd0;
      BITCLOCK_VALID <= 1'b0;
      SAMPLE_RATE_AUTO <= 1'b1;
      SAMPLE_RATE_KHZ10 <= 10'd0;
      SAMPLE_RATE_VALID <= 1'b0;
    end else begin
      SW_FREQ_KHZ <= nxt_sw_khz;
      SW_FREQ_VALID <= nxt_sw_khz != 10'd0;
      BRIDGE_PARALLEL <= regs_ff.out_cfg[BRIDGE_BIT];
      MOD_SCHEME <= adr_mod_t'(regs_ff.out_cfg[MOD_LSB +: 2]);
      PROCESSOR_HOLD <= hold;
      hold_ff <= hold;
      DSP_START <= hold_ff & ~hold;
      MUTE_REQ <= regs_ff.state_ctl[MUTE_BIT];
      POWER_STATE <= adr_power_t'(regs_ff.state_ctl[PSTATE_LSB +: 2]);
      BITCLOCK_RATIO_FS <= nxt_bclk_fs;
      BITCLOCK_VALID <= nxt_bclk_fs != 10'd0;
      SAMPLE_RATE_AUTO <= fs == 4'b0000;
      SAMPLE_RATE_KHZ10 <= nxt_fs_khz10;
      SAMPLE_RATE_VALID <= nxt_fs_khz10 != 10'd0;
    end
  end

  // ----------------------------------------------------------------
  // Soft mute gain ramp
  // ----------------------------------------------------------------
  logic [7:0] step_ff;
  wire step_tick = step_ff == RAMP_LAST;
  wire mute_bit = regs_ff.state_ctl[MUTE_BIT];
  assign MUTE_DONE = VOLUME_GAIN == 8'h00;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      step_ff <= 8'h00;
      VOLUME_GAIN <= GAIN_FULL;
    end else begin
      step_ff <= step_tick ? 8'h00 : step_ff + 8'h01;
      if (step_tick && mute_bit && VOLUME_GAIN != 8'h00) begin
        VOLUME_GAIN <= VOLUME_GAIN - 8'h01;
      end else if (step_tick && !mute_bit && VOLUME_GAIN != GAIN_FULL) begin
        VOLUME_GAIN <= VOLUME_GAIN + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence end_of_page_s;
    adv && ptr_ff.ofs == PAGE_END && ptr_ff.book != 8'h00 && !start_cond && !stop_cond;
  endsequence

  sw_freq_map_a: assert property (fsw == 3'b100 |=> SW_FREQ_KHZ == 10'd576)
    else $error("switching rate not 576 kHz");
  bridge_follow_a: assert property (##1 BRIDGE_PARALLEL == $past(regs_ff.out_cfg[2]))
    else $error("bridge mode does not follow register");
  mod_hybrid_a: assert property (regs_ff.out_cfg[1:0] == 2'b10 |=> MOD_SCHEME == MOD_HYBRID)
    else $error("hybrid modulation not selected");
  dsp_release_a: assert property ($fell(hold) |=> DSP_START ##1 !DSP_START)
    else $error("processor release pulse wrong");
  mute_ramp_a: assert property (step_tick && mute_bit && VOLUME_GAIN != 8'h00 |=>
    VOLUME_GAIN == $past(VOLUME_GAIN) - 8'h01)
    else $error("mute ramp did not step down");
  power_play_a: assert property (regs_ff.state_ctl[1:0] == 2'b11 |=> POWER_STATE == PWR_PLAY)
    else $error("play state not commanded");
  next_page_a: assert property (end_of_page_s ##0 !wrap_dis |=>
    ptr_ff.ofs == 7'h08 && ptr_ff.page == $past(ptr_ff.page) + 8'h01)
    else $error("page advance wrong");
  same_page_a: assert property (end_of_page_s ##0 wrap_dis |=>
    ptr_ff.ofs == 7'h00 && ptr_ff.page == $past(ptr_ff.page))
    else $error("page wrap wrong");
  bclk_ratio_a: assert property (bclk == 4'b1001 |=> BITCLOCK_RATIO_FS == 10'd256)
    else $error("bit clock ratio not 256");
  rate_48k_a: assert property (fs == 4'b1001 |=> SAMPLE_RATE_KHZ10 == 10'd480 && SAMPLE_RATE_VALID)
    else $error("48 kHz not selected");
endmodule
`default_nettype wire

// [verif/adr_host_model.sv]
// Purpose: Host controller model on the two-wire control port
// Assumes: Open-drain data line with pull-up, CLK far faster than SCL
// Notes: Each byte read is announced through the got event
`timescale 1ns/1ps
`default_nettype none
module adr_host_model (
  input wire logic CLK,
  input wire logic DEV_OE,
  output logic SCL,
  output logic SDA
);
  logic host_oe = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  event got;
  // Pull-up unless a party pulls low
  assign SDA = ~(host_oe | DEV_OE);
  initial SCL = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Data only moves while SCL is low
  task automatic bit_out(input logic b, output logic seen);
    hold(1);
    host_oe <= ~b;
    hold(2);
    SCL <= 1'b1;
    hold(2);
    seen = SDA;
    hold(2);
    SCL <= 1'b0;
  endtask
  // Data edge while SCL high: start or stop
  task automatic cond(input logic a, input logic b);
    hold(1);
    host_oe <= a;
    hold(2);
    SCL <= 1'b1;
    hold(3);
    host_oe <= b;
    hold(3);
  endtask
  task automatic start();
    cond(1'b0, 1'b1);
    SCL <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(tx[i], rx[i]);
    end
    bit_out(last, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [6:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic k0;
    logic k1;
    logic k2;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, k0);
    xfer({1'b0, a}, 1'b1, rx, k1);
    xfer(d, 1'b1, rx, k2);
    cond(1'b1, 1'b0);
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [6:0] a, input int n);
    logic [7:0] rx;
    logic k;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, k);
    xfer({1'b0, a}, 1'b1, rx, k);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, k);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, rx, k);
      rd_byte = rx;
      -> got;
    end
    cond(1'b1, 1'b0);
  endtask
endmodule
`default_nettype wire

// [verif/adr_ctrl_regs_bench.sv]
// Purpose: Self-checking bench for the amplifier control register bank
// Assumes: Host model drives the control port
// Notes: Read bytes are compared against a queue of expected notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module adr_ctrl_regs_bench
  import adr_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic SCL, SDA, SDA_OUT, SDA_OE, SW_FREQ_VALID, BRIDGE_PARALLEL, PROCESSOR_HOLD;
  logic DSP_START, MUTE_REQ, MUTE_DONE, BITCLOCK_VALID, SAMPLE_RATE_AUTO, SAMPLE_RATE_VALID;
  logic [9:0] SW_FREQ_KHZ, BITCLOCK_RATIO_FS, SAMPLE_RATE_KHZ10;
  logic [7:0] VOLUME_GAIN;
  adr_mod_t MOD_SCHEME;
  adr_power_t POWER_STATE;
  logic [7:0] exp_q [$];
  logic [7:0] exp_b;
  logic ok;
  int fail_count = 0;
  int samples_checked = 0;
  int dsp_cnt = 0;
  logic [9:0] fsw_t [8] = '{10'h300, 10'h180, 10'h000, 10'h1E0, 10'h240, 10'h000, 10'h000,
                            10'h000};
  // Legal switching codes only, reserved ones stay unwritten
  logic [2:0] fsw_c [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic [9:0] bck_t [16] = '{3: 10'h020, 5: 10'h040, 7: 10'h080, 9: 10'h100, 11: 10'h200,
                             default: 10'h000};
  logic [9:0] fs_t [16] = '{2: 10'h050, 4: 10'h0A0, 6: 10'h140, 8: 10'h1B9, 9: 10'h1E0,
                            11: 10'h3C0, default: 10'h000};
  adr_ctrl_regs i_dut (.CLK(CLK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .SW_FREQ_KHZ(SW_FREQ_KHZ), .SW_FREQ_VALID(SW_FREQ_VALID),
    .BRIDGE_PARALLEL(BRIDGE_PARALLEL), .MOD_SCHEME(MOD_SCHEME), .PROCESSOR_HOLD(PROCESSOR_HOLD),
    .DSP_START(DSP_START), .MUTE_REQ(MUTE_REQ), .VOLUME_GAIN(VOLUME_GAIN), .MUTE_DONE(MUTE_DONE),
    .POWER_STATE(POWER_STATE), .BITCLOCK_RATIO_FS(BITCLOCK_RATIO_FS),
    .BITCLOCK_VALID(BITCLOCK_VALID), .SAMPLE_RATE_AUTO(SAMPLE_RATE_AUTO),
    .SAMPLE_RATE_KHZ10(SAMPLE_RATE_KHZ10), .SAMPLE_RATE_VALID(SAMPLE_RATE_VALID));
  adr_host_model i_host (.CLK(CLK), .DEV_OE(SDA_OE), .SCL(SCL), .SDA(SDA));
  initial begin
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (DSP_START === 1'b1)
      dsp_cnt <= dsp_cnt + 1;
  end
  // Oldest note against each byte read
  always @(i_host.got) begin
    exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    `CHK("read data", exp_b, i_host.rd_byte)
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    i_host.wr(DEV, a, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(DEV, a, 1);
  endtask
  task automatic wait_gain(input logic [7:0] g);
    int n;
    n = 0;
    while (VOLUME_GAIN !== g && n < 6000) begin
      tick(1);
      n++;
    end
    `CHK("ramp cycles", 1'b1, n > 4800 && n < 6000)
    if (n >= 6000)
      end_sim();
  endtask
  task automatic reset_chk();
    `CHK("sw freq", 10'h300, SW_FREQ_KHZ)
    `CHK("hold", 1'b1, PROCESSOR_HOLD)
    `CHK("gain", 8'hFF, VOLUME_GAIN)
    `CHK("power", PWR_DEEP_SLEEP, POWER_STATE)
    `CHK("rate auto", 1'b1, SAMPLE_RATE_AUTO)
    `CHK("sda out", 1'b0, SDA_OUT)
    rchk(OFS_OUT_CFG, 8'h00);
    rchk(OFS_STATE_CTL, 8'h10);
    rchk(OFS_PAGE_INC, 8'h00);
    rchk(OFS_FRAME_CFG, 8'h00);
    $display("test reset values done");
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] v;
    void'($urandom(312));
    tick(10);
    RESET <= 1'b0;
    tick(2);
    reset_chk();
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, fsw_c[i % 4], 1'b0, 1'($urandom_range(1, 0)), 2'($urandom_range(2, 0))};
      wreg(OFS_OUT_CFG, v);
      `CHK("sw freq", fsw_t[v[6:4]], SW_FREQ_KHZ)
      `CHK("sw valid", fsw_t[v[6:4]] != 10'h000, SW_FREQ_VALID)
      `CHK("bridge", v[2], BRIDGE_PARALLEL)
      `CHK("mod", v[1:0], MOD_SCHEME)
      rchk(OFS_OUT_CFG, v);
    end
    $display("test output config done");
    for (int p = 0; p < 4; p++) begin
      wreg(OFS_STATE_CTL, 8'h10 | 8'(p));
      `CHK("power", p[1:0], POWER_STATE)
      `CHK("hold", 1'b1, PROCESSOR_HOLD)
    end
    n = dsp_cnt;
    // no audio clocks, so all settled
    wreg(OFS_STATE_CTL, 8'h03);
    `CHK("hold", 1'b0, PROCESSOR_HOLD)
    `CHK("start pulses", n + 1, dsp_cnt)
    wreg(OFS_STATE_CTL, 8'h13);
    wreg(OFS_STATE_CTL, 8'h03);
    `CHK("start pulses", n + 2, dsp_cnt)
    $display("test state control done");
    wreg(OFS_STATE_CTL, 8'h0B);
    `CHK("mute req", 1'b1, MUTE_REQ)
    tick(60);
    `CHK("ramp gradual", 1'b1, VOLUME_GAIN > 8'h00 && VOLUME_GAIN < 8'hFF)
    wait_gain(8'h00);
    `CHK("mute done", 1'b1, MUTE_DONE)
    wreg(OFS_STATE_CTL, 8'h03);
    `CHK("mute req", 1'b0, MUTE_REQ)
    wait_gain(8'hFF);
    rchk(OFS_STATE_CTL, 8'h03);
    $display("test soft mute done");
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 4'(15 - i)};
      wreg(OFS_FRAME_CFG, v);
      `CHK("bck ratio", bck_t[i], BITCLOCK_RATIO_FS)
      `CHK("bck valid", bck_t[i] != 10'h000, BITCLOCK_VALID)
      `CHK("rate", fs_t[15 - i], SAMPLE_RATE_KHZ10)
      `CHK("rate valid", fs_t[15 - i] != 10'h000, SAMPLE_RATE_VALID)
      `CHK("rate auto", i == 15, SAMPLE_RATE_AUTO)
      rchk(OFS_FRAME_CFG, v);
    end
    $display("test frame config done");
    wreg(OFS_PAGE_INC, 8'h08);
    wreg(OFS_OUT_CFG, 8'h41);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h08);
    // Unmapped byte then wrap control, one burst
    i_host.rd(DEV, 7'h0E, 2);
    i_host.wr(DEV ^ 7'h01, OFS_OUT_CFG, 8'h5A, ok);
    `CHK("foreign ack", 1'b0, ok)
    // Non-zero book page end, wrap disabled then enabled
    wreg(OFS_BOOK_SEL, 8'h01);
    wreg(OFS_PAGE_SEL, 8'h05);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h05);
    i_host.rd(DEV, PAGE_END, 2);
    wreg(OFS_PAGE_SEL, 8'h00);
    wreg(OFS_BOOK_SEL, 8'h00);
    wreg(OFS_PAGE_INC, 8'h00);
    wreg(OFS_BOOK_SEL, 8'h01);
    wreg(OFS_PAGE_SEL, 8'h05);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    i_host.rd(DEV, PAGE_END, 2);
    rchk(OFS_PAGE_SEL, 8'h06);
    wreg(OFS_PAGE_SEL, 8'h00);
    wreg(OFS_BOOK_SEL, 8'h00);
    rchk(OFS_OUT_CFG, 8'h41);
    $display("test addressing done");
    RESET <= 1'b1;
    tick(3);
    RESET <= 1'b0;
    tick(2);
    reset_chk();
    end_sim();
  end
endmodule
`default_nettype wire
